// *** src/port_ab_map.vh ***
// register offsets, field positions and reset values for the port a/b override block
`ifndef PORT_AB_MAP_VH
`define PORT_AB_MAP_VH

// apb register byte offsets
`define REG_MCU_CTRL      12'h000
`define REG_PORTA_DIR     12'h004
`define REG_PORTA_OUT     12'h008
`define REG_PORTA_IN      12'h00C
`define REG_PORTB_DIR     12'h010
`define REG_PORTB_OUT     12'h014
`define REG_PORTB_IN      12'h018
`define REG_ALT_CTRL      12'h01C
`define REG_PIN_STATUS    12'h020

// field positions
`define MCU_PULLUP_DIS_BIT 4
`define ALT_EXT_MEM_BIT    0
`define ALT_B7_SEL_BIT     1
`define ALT_SPI_EN_BIT     2
`define ALT_SPI_MSTR_BIT   3

// reset values
`define RST_BYTE          8'h00
`define RST_WORD          32'h00000000
`define PORT_WIDTH        8

`endif

// *** src/port_pin_cell.v ***
// one pin's override mux: pull-up, direction and value selection
`timescale 1ns/1ps
module port_pin_cell (
  // register bits and global control
  input  wire pin_direction_bit,
  input  wire pin_output_bit,
  input  wire global_pullup_disable,
  // override signals from the alternate function
  input  wire pullup_override_enable,
  input  wire pullup_override_value,
  input  wire direction_override_enable,
  input  wire direction_override_value,
  input  wire value_override_enable,
  input  wire value_override_value,
  // pad-side results
  output wire pad_out,
  output wire pad_oe,
  output wire pad_pullup
);

  // normal pull-up only for input with output bit high and no global disable
  wire normal_pullup;
  assign normal_pullup = ~pin_direction_bit & pin_output_bit & ~global_pullup_disable;
  assign pad_pullup    = pullup_override_enable ? pullup_override_value : normal_pullup;

  // driver enable follows the register unless overridden
  assign pad_oe = direction_override_enable ? direction_override_value : pin_direction_bit;

  // override value wins over the output register when active
  assign pad_out = value_override_enable ? value_override_value : pin_output_bit;

endmodule

// *** src/pin_sync.v ***
// two-flop synchroniser for a bus of pad inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // raw and synchronised data
  input  wire [WIDTH-1:0] raw_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r   <= raw_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** src/port_ab_override.v ***
// port a/b alternate-function override block with apb register access
//
// Contract
// - global disable turns all pull-ups off
// - port a pins carry muxed address/data
// - ext memory: pull-ups off during address/write
// - ext memory owns port a direction
// - ext memory drives address or write data
// - port a input feeds data in; no toggle
// - address-active qualifier marks address phase
// - pin b7 can output timer0 compare a
// - pin b7 alternatively outputs timer1 compare c
// - pb6 outputs timer1 compare b
// - compare pins also carry pwm waveforms
// - pb3..pb0 carry spi signals
// - compare enable overrides value only
// - normal pull-up: input, bit one, enabled
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "port_ab_map.vh"
module port_ab_override #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // apb slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  // external memory interface side
  input  wire             address_phase_active,
  input  wire             ext_write_active,
  input  wire [WIDTH-1:0] ext_addr_low,
  input  wire [WIDTH-1:0] ext_data_out,
  output reg  [WIDTH-1:0] ext_data_in,
  // timer compare / pwm outputs and their enables
  input  wire             timer0_compare_a_out,
  input  wire             timer0_compare_a_en,
  input  wire             timer1_compare_c_out,
  input  wire             timer1_compare_c_en,
  input  wire             timer1_compare_b_out,
  input  wire             timer1_compare_b_en,
  input  wire             timer1_compare_a_out,
  input  wire             timer1_compare_a_en,
  input  wire             timer2_compare_a_out,
  input  wire             timer2_compare_a_en,
  // spi core side
  input  wire             spi_slave_out,
  input  wire             spi_master_out,
  input  wire             spi_sck_out,
  output reg              spi_master_in,
  output reg              spi_slave_in,
  output reg              spi_sck_in,
  output reg              spi_select_in,
  // port a pads
  input  wire [WIDTH-1:0] port_a_in,
  output reg  [WIDTH-1:0] port_a_out,
  output reg  [WIDTH-1:0] port_a_oe,
  output reg  [WIDTH-1:0] port_a_pullup,
  // port b pads
  input  wire [WIDTH-1:0] port_b_in,
  output reg  [WIDTH-1:0] port_b_out,
  output reg  [WIDTH-1:0] port_b_oe,
  output reg  [WIDTH-1:0] port_b_pullup
);

  // software-visible control state
  reg             global_pullup_disable_r;
  reg [WIDTH-1:0] porta_dir_r;
  reg [WIDTH-1:0] porta_out_r;
  reg [WIDTH-1:0] portb_dir_r;
  reg [WIDTH-1:0] portb_out_r;
  reg             ext_memory_enable_r;
  reg             b7_use_timer1_r;
  reg             spi_enable_r;
  reg             spi_master_r;

  wire [WIDTH-1:0] porta_sync;
  wire [WIDTH-1:0] portb_sync;

  // combinational override vectors, one bit per pin
  reg  [WIDTH-1:0] a_pull_ovr_en;
  reg  [WIDTH-1:0] a_pull_ovr_val;
  reg  [WIDTH-1:0] a_dir_ovr_en;
  reg  [WIDTH-1:0] a_dir_ovr_val;
  reg  [WIDTH-1:0] a_val_ovr_en;
  reg  [WIDTH-1:0] a_val_ovr_val;
  reg  [WIDTH-1:0] b_pull_ovr_en;
  reg  [WIDTH-1:0] b_pull_ovr_val;
  reg  [WIDTH-1:0] b_dir_ovr_en;
  reg  [WIDTH-1:0] b_dir_ovr_val;
  reg  [WIDTH-1:0] b_val_ovr_en;
  reg  [WIDTH-1:0] b_val_ovr_val;
  wire [WIDTH-1:0] a_pad_out;
  wire [WIDTH-1:0] a_pad_oe;
  wire [WIDTH-1:0] a_pad_pu;
  wire [WIDTH-1:0] b_pad_out;
  wire [WIDTH-1:0] b_pad_oe;
  wire [WIDTH-1:0] b_pad_pu;

  wire apb_write;
  wire spi_master_mode;
  wire spi_slave_mode;
  wire ext_drive;
  wire b7_cmp_en;
  wire b7_cmp_val;

  // zero-wait apb: every access completes in its first access cycle
  // no wait states needed, the register file and read mux settle in one cycle
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign apb_write = psel & penable & pwrite;

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_pullup_disable_r <= 1'b0;
      porta_dir_r             <= `RST_BYTE;
      porta_out_r             <= `RST_BYTE;
      portb_dir_r             <= `RST_BYTE;
      portb_out_r             <= `RST_BYTE;
      ext_memory_enable_r     <= 1'b0;
      b7_use_timer1_r         <= 1'b0;
      spi_enable_r            <= 1'b0;
      spi_master_r            <= 1'b0;
    end else if (apb_write) begin
      case (paddr)
        `REG_MCU_CTRL: global_pullup_disable_r <= pwdata[`MCU_PULLUP_DIS_BIT];
        `REG_PORTA_DIR: porta_dir_r <= pwdata[WIDTH-1:0];
        `REG_PORTA_OUT: porta_out_r <= pwdata[WIDTH-1:0];
        `REG_PORTB_DIR: portb_dir_r <= pwdata[WIDTH-1:0];
        `REG_PORTB_OUT: portb_out_r <= pwdata[WIDTH-1:0];
        `REG_ALT_CTRL: begin
          ext_memory_enable_r <= pwdata[`ALT_EXT_MEM_BIT];
          b7_use_timer1_r     <= pwdata[`ALT_B7_SEL_BIT];
          spi_enable_r        <= pwdata[`ALT_SPI_EN_BIT];
          spi_master_r        <= pwdata[`ALT_SPI_MSTR_BIT];
        end
        // status and input words are read-only, writes fall to default
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    prdata = `RST_WORD;
    case (paddr)
      `REG_MCU_CTRL:   prdata[`MCU_PULLUP_DIS_BIT] = global_pullup_disable_r;
      `REG_PORTA_DIR:  prdata[WIDTH-1:0] = porta_dir_r;
      `REG_PORTA_OUT:  prdata[WIDTH-1:0] = porta_out_r;
      `REG_PORTA_IN:   prdata[WIDTH-1:0] = porta_sync;
      `REG_PORTB_DIR:  prdata[WIDTH-1:0] = portb_dir_r;
      `REG_PORTB_OUT:  prdata[WIDTH-1:0] = portb_out_r;
      `REG_PORTB_IN:   prdata[WIDTH-1:0] = portb_sync;
      `REG_ALT_CTRL: begin
        prdata[`ALT_EXT_MEM_BIT]  = ext_memory_enable_r;
        prdata[`ALT_B7_SEL_BIT]   = b7_use_timer1_r;
        prdata[`ALT_SPI_EN_BIT]   = spi_enable_r;
        prdata[`ALT_SPI_MSTR_BIT] = spi_master_r;
      end
      `REG_PIN_STATUS: begin
        prdata[WIDTH-1:0]       = port_a_oe;
        prdata[2*WIDTH-1:WIDTH] = port_b_oe;
      end
      default: prdata = `RST_WORD;
    endcase
  end

  // input synchronisers for software reads
  pin_sync #(.WIDTH(WIDTH)) u_sync_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .raw_in   (port_a_in),
    .sync_out (porta_sync)
  );
  pin_sync #(.WIDTH(WIDTH)) u_sync_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .raw_in   (port_b_in),
    .sync_out (portb_sync)
  );

  // bus drives only while address or write data is out
  assign ext_drive = address_phase_active | ext_write_active;

  // port a: external memory takes every bit of the multiplexed bus
  // pull-ups go off while driving so the pad never burns current in its own resistor
  always @* begin
    a_pull_ovr_en  = {WIDTH{ext_memory_enable_r & ext_drive}};
    a_pull_ovr_val = {WIDTH{1'b0}};
    a_dir_ovr_en   = {WIDTH{ext_memory_enable_r}};
    a_dir_ovr_val  = {WIDTH{ext_drive}};
    a_val_ovr_en   = {WIDTH{ext_memory_enable_r}};
    // bit n of the pin carries address bit n, then data bit n
    a_val_ovr_val  = (ext_addr_low & {WIDTH{address_phase_active}})
                   | (ext_data_out & {WIDTH{ext_write_active}});
  end

  // pin b7 source: timer1 channel c when selected, else timer0 channel a
  // one select bit instead of a priority scheme, so both enables never fight
  assign b7_cmp_en  = b7_use_timer1_r ? timer1_compare_c_en  : timer0_compare_a_en;
  assign b7_cmp_val = b7_use_timer1_r ? timer1_compare_c_out : timer0_compare_a_out;

  // spi role decode, shared by the four spi pins
  assign spi_master_mode = spi_enable_r & spi_master_r;
  assign spi_slave_mode  = spi_enable_r & ~spi_master_r;

  // port b overrides; compare pins touch value only, pwm rides the same path
  // limitation: spi pull-ups keep plain register control, no forced pull-up term
  always @* begin
    b_pull_ovr_en    = {WIDTH{1'b0}};
    b_pull_ovr_val   = {WIDTH{1'b0}};
    b_dir_ovr_en     = {WIDTH{1'b0}};
    b_dir_ovr_val    = {WIDTH{1'b0}};
    b_val_ovr_en     = {WIDTH{1'b0}};
    b_val_ovr_val    = {WIDTH{1'b0}};
    b_val_ovr_en[7]  = b7_cmp_en;
    b_val_ovr_val[7] = b7_cmp_val;
    b_val_ovr_en[6]  = timer1_compare_b_en;
    b_val_ovr_val[6] = timer1_compare_b_out;
    b_val_ovr_en[5]  = timer1_compare_a_en;
    b_val_ovr_val[5] = timer1_compare_a_out;
    b_val_ovr_en[4]  = timer2_compare_a_en;
    b_val_ovr_val[4] = timer2_compare_a_out;
    // spi: master forces miso in, slave forces mosi/sck/select in
    // forced inputs keep direction value zero from the defaults above
    b_dir_ovr_en[3]  = spi_master_mode;
    b_val_ovr_en[3]  = spi_slave_mode;
    b_val_ovr_val[3] = spi_slave_out;
    b_dir_ovr_en[2]  = spi_slave_mode;
    b_val_ovr_en[2]  = spi_master_mode;
    b_val_ovr_val[2] = spi_master_out;
    b_dir_ovr_en[1]  = spi_slave_mode;
    b_val_ovr_en[1]  = spi_master_mode;
    b_val_ovr_val[1] = spi_sck_out;
    b_dir_ovr_en[0]  = spi_slave_mode;
  end

  // per-pin muxes
  // both ports share one cell so pull-up and driver rules cannot drift apart
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      port_pin_cell u_a (
        .pin_direction_bit         (porta_dir_r[g]),
        .pin_output_bit            (porta_out_r[g]),
        .global_pullup_disable     (global_pullup_disable_r),
        .pullup_override_enable    (a_pull_ovr_en[g]),
        .pullup_override_value     (a_pull_ovr_val[g]),
        .direction_override_enable (a_dir_ovr_en[g]),
        .direction_override_value  (a_dir_ovr_val[g]),
        .value_override_enable     (a_val_ovr_en[g]),
        .value_override_value      (a_val_ovr_val[g]),
        .pad_out                   (a_pad_out[g]),
        .pad_oe                    (a_pad_oe[g]),
        .pad_pullup                (a_pad_pu[g])
      );
      port_pin_cell u_b (
        .pin_direction_bit         (portb_dir_r[g]),
        .pin_output_bit            (portb_out_r[g]),
        .global_pullup_disable     (global_pullup_disable_r),
        .pullup_override_enable    (b_pull_ovr_en[g]),
        .pullup_override_value     (b_pull_ovr_val[g]),
        .direction_override_enable (b_dir_ovr_en[g]),
        .direction_override_value  (b_dir_ovr_val[g]),
        .value_override_enable     (b_val_ovr_en[g]),
        .value_override_value      (b_val_ovr_val[g]),
        .pad_out                   (b_pad_out[g]),
        .pad_oe                    (b_pad_oe[g]),
        .pad_pullup                (b_pad_pu[g])
      );
    end
  endgenerate

  // pad outputs are combinational so bus timing follows the memory phases
  // a register here would delay the address by a cycle behind its qualifier
  always @* begin
    port_a_out    = a_pad_out;
    port_a_oe     = a_pad_oe;
    port_a_pullup = a_pad_pu;
    port_b_out    = b_pad_out;
    port_b_oe     = b_pad_oe;
    port_b_pullup = b_pad_pu;
  end

  // raw pad inputs to alternate functions; each core synchronises its own
  // limitation: these bypass the register synchronisers, never use them unsynced
  always @* begin
    ext_data_in   = port_a_in;
    spi_master_in = port_b_in[3];
    spi_slave_in  = port_b_in[2];
    spi_sck_in    = port_b_in[1];
    spi_select_in = port_b_in[0];
  end

endmodule

// *** verification/port_ab_override_sva.sv ***
// concurrent checks on the pad side of the port a/b override block
`timescale 1ns/1ps
module port_ab_override_sva #(
  parameter WIDTH = 8
) (
  // clock, reset and apb
  input wire             pclk,
  input wire             presetn,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [11:0]      paddr,
  input wire [31:0]      pwdata,
  input wire             pready,
  // memory side and timer/spi
  input wire             address_phase_active,
  input wire             ext_write_active,
  input wire [WIDTH-1:0] ext_addr_low,
  input wire [WIDTH-1:0] ext_data_out,
  input wire [WIDTH-1:0] ext_data_in,
  input wire             timer1_compare_b_out,
  input wire             timer1_compare_b_en,
  input wire             spi_select_in,
  input wire             spi_master_in,
  input wire             spi_slave_in,
  input wire             spi_sck_in,
  // pads
  input wire [WIDTH-1:0] port_a_in,
  input wire [WIDTH-1:0] port_a_out,
  input wire [WIDTH-1:0] port_a_oe,
  input wire [WIDTH-1:0] port_a_pullup,
  input wire [WIDTH-1:0] port_b_in,
  input wire [WIDTH-1:0] port_b_out,
  input wire [WIDTH-1:0] port_b_pullup
);
  reg  em_r;
  reg  pull_dis_r;
  wire wr_go = psel && penable && pwrite && pready;
  wire bus_on = address_phase_active | ext_write_active;
  // shadow of two control bits, so no peeking into the design
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      em_r  <= 1'b0;
      pull_dis_r <= 1'b0;
    end else begin
      if (wr_go && paddr == 12'h01C) em_r <= pwdata[0];
      if (wr_go && paddr == 12'h000) pull_dis_r <= pwdata[4];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ext_in_a: assert property (ext_data_in == port_a_in)
    else $error("memory data in differs from port a pins");
  em_dir_a: assert property (em_r |-> port_a_oe == {WIDTH{bus_on}})
    else $error("port a direction not owned by memory bus");
  addr_out_a: assert property (em_r && address_phase_active && !ext_write_active |-> port_a_out == ext_addr_low)
    else $error("address not on port a");
  wdata_out_a: assert property (em_r && ext_write_active && !address_phase_active |-> port_a_out == ext_data_out)
    else $error("write data not on port a");
  em_pull_a: assert property (em_r && bus_on |-> port_a_pullup == {WIDTH{1'b0}})
    else $error("port a pull-up on while bus driven");
  pull_dis_a: assert property (pull_dis_r |-> (port_a_pullup | port_b_pullup) == {WIDTH{1'b0}})
    else $error("pull-up on while globally disabled");
  norm_pull_a: assert property (!em_r |-> port_a_pullup == (~port_a_oe & port_a_out & {WIDTH{~pull_dis_r}}))
    else $error("port a pull-up wrong");
  pb6_cmp_a: assert property (timer1_compare_b_en |-> port_b_out[6] == timer1_compare_b_out)
    else $error("pin b6 does not follow compare b");
  spi_ss_a: assert property (spi_select_in == port_b_in[0])
    else $error("select input not from pin b0");
  spi_din_a: assert property ({spi_master_in, spi_slave_in, spi_sck_in} == port_b_in[3:1])
    else $error("spi inputs not from pins b3 to b1");
endmodule
bind port_ab_override port_ab_override_sva #(.WIDTH(WIDTH)) chk (.*);

// *** verification/ext_mem_model.sv ***
// external parallel memory on the multiplexed port a lines
`timescale 1ns/1ps
module ext_mem_model (
  // clock and bus strobes
  input  wire       pclk,
  input  wire       latch_en,
  input  wire       wr_en,
  input  wire       rd_en,
  // multiplexed lines
  input  wire [7:0] bus_out,
  input  wire [7:0] bus_oe,
  input  wire [7:0] bus_pullup,
  output wire [7:0] bus_in
);
  reg [7:0] mem [0:255];
  reg [7:0] adr_r;
  reg [7:0] last_r = 8'h00;
  // address taken while presented, data while written
  always @(posedge pclk) begin
    if (latch_en) adr_r <= bus_out;
    if (wr_en) mem[adr_r] <= bus_out;
    last_r <= bus_in;
  end
  // released bits toggle unless pulled up, so stale data never passes for a read
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & (rd_en ? mem[adr_r] : (bus_pullup | ~last_r)));
endmodule

// *** verification/port_ab_override_tb_top.sv ***
// self-checking bench for the port a/b override block
`timescale 1ns/1ps
module port_ab_override_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic        address_phase_active, ext_write_active, mem_rd, look;
  logic [7:0]  ext_addr_low, ext_data_out, ext_data_in;
  logic        timer0_compare_a_out, timer0_compare_a_en, timer1_compare_c_out, timer1_compare_c_en;
  logic        timer1_compare_b_out, timer1_compare_b_en, timer1_compare_a_out, timer1_compare_a_en;
  logic        timer2_compare_a_out, timer2_compare_a_en;
  logic        spi_slave_out, spi_master_out, spi_sck_out;
  logic        spi_master_in, spi_slave_in, spi_sck_in, spi_select_in;
  logic [7:0]  port_a_in, port_a_out, port_a_oe, port_a_pullup;
  logic [7:0]  port_b_in, port_b_out, port_b_oe, port_b_pullup;
  logic [31:0] rdq[$];
  logic [9:0]  padq[$];
  logic [9:0]  pn;
  logic [7:0]  pads[4];
  string       pnames[4] = '{"port_a_out", "port_a_pullup", "port_b_out", "ext_data_in"};
  int          miscompares, samples_checked, cyc, i;

  port_ab_override #(.WIDTH(8)) dut (.*);
  ext_mem_model mem (.pclk(pclk), .latch_en(address_phase_active), .wr_en(ext_write_active), .rd_en(mem_rd),
    .bus_out(port_a_out), .bus_oe(port_a_oe), .bus_pullup(port_a_pullup), .bus_in(port_a_in));
  assign pads = '{port_a_out, port_a_pullup, port_b_out, ext_data_in};

  // 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one apb transfer; held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    rdq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // note a pad value; the watcher samples it one edge later
  task chk_pad(input logic [1:0] s, input logic [7:0] e);
    @(posedge pclk);
    padq.push_back({s, e});
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask

  // write then read back one byte over the muxed bus
  task mem_cycle(input logic [7:0] a, input logic [7:0] d);
    address_phase_active <= 1'b1;
    ext_addr_low <= a;
    chk_pad(2'd0, a);
    address_phase_active <= 1'b0;
    ext_write_active <= 1'b1;
    ext_data_out <= d;
    chk_pad(2'd0, d);
    ext_write_active <= 1'b0;
    address_phase_active <= 1'b1;
    chk_pad(2'd1, 8'h00);
    address_phase_active <= 1'b0;
    mem_rd <= 1'b1;
    chk_pad(2'd3, d);
    mem_rd <= 1'b0;
  endtask

  // watchers: each result is matched to the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) cmp("prdata", rdq.pop_front(), prdata);
    if (psel && penable && pready === 1'b1) cmp("pslverr", 32'h0, {31'h0, pslverr});
    if (look === 1'b1) begin
      pn = padq.pop_front();
      cmp(pnames[pn[9:8]], {24'h0, pn[7:0]}, {24'h0, pads[pn[9:8]]});
    end
  end

  // hang guard, well above the expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    seed = 32'h000083C1;
    {psel, penable, pwrite, look, mem_rd, address_phase_active, ext_write_active} = '0;
    {paddr, pwdata, ext_addr_low, ext_data_out, port_b_in} = '0;
    {timer0_compare_a_out, timer0_compare_a_en, timer1_compare_c_out, timer1_compare_c_en} = '0;
    {timer1_compare_b_out, timer1_compare_b_en, timer1_compare_a_out, timer1_compare_a_en} = '0;
    {timer2_compare_a_out, timer2_compare_a_en, spi_slave_out, spi_master_out, spi_sck_out} = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h020, 32'h0);
    rd(12'h0FC, 32'h0);
    // port a as plain i/o, then global pull-up off
    r = rnd();
    apb(1'b1, 12'h004, 32'h0F);
    apb(1'b1, 12'h008, {24'h0, r[7:0]});
    chk_pad(2'd0, r[7:0]);
    chk_pad(2'd1, r[7:0] & 8'hF0);
    apb(1'b1, 12'h000, 32'h10);
    chk_pad(2'd1, 8'h00);
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h004, 32'h0F);
    // port b compare pins and both sources of pin 7
    apb(1'b1, 12'h010, 32'hC0);
    apb(1'b1, 12'h014, 32'h3C);
    chk_pad(2'd2, 8'h3C);
    {timer0_compare_a_en, timer0_compare_a_out, timer1_compare_c_en, timer1_compare_c_out} <= 4'hE;
    {timer1_compare_b_en, timer1_compare_b_out, timer1_compare_a_en, timer1_compare_a_out} <= 4'hF;
    {timer2_compare_a_en, timer2_compare_a_out} <= 2'b10;
    chk_pad(2'd2, 8'hEC);
    apb(1'b1, 12'h01C, 32'h2);
    chk_pad(2'd2, 8'h6C);
    apb(1'b1, 12'h020, 32'hFFFF);
    rd(12'h020, 32'h0000C00F);
    // spi master, then slave, takes over the low pins of port b
    apb(1'b1, 12'h010, 32'h0F);
    {spi_slave_out, spi_master_out, spi_sck_out} <= 3'b001;
    apb(1'b1, 12'h01C, 32'hC);
    rd(12'h020, 32'h0000070F);
    chk_pad(2'd2, 8'hEA);
    apb(1'b1, 12'h01C, 32'h4);
    rd(12'h020, 32'h0000080F);
    chk_pad(2'd2, 8'hE4);
    // memory bus takes over port a
    apb(1'b1, 12'h01C, 32'h1);
    rd(12'h020, 32'h00000F00);
    for (i = 0; i < 4; i++) begin
      r = rnd();
      {port_b_in, spi_slave_out, spi_master_out, spi_sck_out} <= r[31:21];
      mem_cycle(r[7:0], r[15:8]);
    end
    close_out();
  end
endmodule
